//--- adrp_consts.svh
// Constants for the converter result byte port
`ifndef ADRP_CONSTS_SVH
`define ADRP_CONSTS_SVH

`define ADRP_RES_W 12
`define ADRP_SER_BITS 4'hc
`define ADRP_CLK_PERIOD_NS 10
`define ADRP_SCLK_HALF_NS 50
`define ADRP_SCLK_HALF_CYC (`ADRP_SCLK_HALF_NS / `ADRP_CLK_PERIOD_NS)
`define ADRP_CONV_DEF 16'h03e8

`define ADRP_REG_CTRL 8'h00
`define ADRP_REG_STATUS 8'h04
`define ADRP_REG_RESULT 8'h08

`define ADRP_ST_BUSY 0
`define ADRP_ST_BYTE 1
`define ADRP_ST_FMT 2
`define ADRP_ST_EXT 3
`define ADRP_ST_SER 4

`endif

//--- adrp_pkg.sv
// Types for the converter result byte port
package adrp_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } adrp_state_t;
  typedef logic [11:0] adrp_code_t;
endpackage

//--- adrp_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module adrp_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_r <= '0;
      q_out <= '0;
    end else begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end
endmodule // adrp_sync

//--- adrp_ser.sv
// Serial result shifter, internal or external bit clock
`include "adrp_consts.svh"
`timescale 1ns/10ps
module adrp_ser
  import adrp_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire logic ext_mode_in,
  input wire logic ext_clk_in,
  input wire adrp_code_t data_in,
  output logic sclk_out,
  output logic sclk_oe_n_out,
  output logic sdata_out,
  output logic active_out
);
  localparam logic [7:0] HALF = 8'(`ADRP_SCLK_HALF_CYC);
  logic [7:0] div_r;
  logic [4:0] tog_r;
  logic [3:0] bits_r;
  logic [11:0] sh_r;
  logic ext_d_r;
  logic tick;
  logic ext_fall;

  assign tick = active_out && !ext_mode_in && (div_r == HALF - 8'h01);
  assign ext_fall = ext_d_r && !ext_clk_in;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ext_d_r <= 1'b0;
    end else begin
      ext_d_r <= ext_clk_in;
    end
  end

  // Internal clock divider
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_r <= 8'h00;
    end else if (start_in || tick || !active_out) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      active_out <= 1'b0;
      sclk_out <= 1'b0;
      tog_r <= 5'h00;
      bits_r <= 4'h0;
      sh_r <= 12'h000;
      sdata_out <= 1'b0;
    end else if (start_in) begin
      active_out <= 1'b1;
      sclk_out <= 1'b0;
      tog_r <= 5'h00;
      bits_r <= 4'h0;
      sh_r <= data_in;
      sdata_out <= data_in[11];
    end else if (tick) begin
      sclk_out <= ~sclk_out;
      tog_r <= tog_r + 5'h01;
      if (sclk_out) begin
        sh_r <= {sh_r[10:0], 1'b0};
        sdata_out <= sh_r[10];
      end
      if (tog_r == 5'h17) begin
        active_out <= 1'b0;
        sclk_out <= 1'b0;
      end
    end else if (active_out && ext_mode_in && ext_fall) begin
      sh_r <= {sh_r[10:0], 1'b0};
      sdata_out <= sh_r[10];
      bits_r <= bits_r + 4'h1;
      if (bits_r == `ADRP_SER_BITS - 4'h1) begin
        active_out <= 1'b0;
      end
    end
  end

  // Pin direction follows the clock source
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sclk_oe_n_out <= 1'b1;
    end else begin
      sclk_oe_n_out <= ext_mode_in;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  logic [4:0] rise_cnt_r;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rise_cnt_r <= 5'h00;
    end else if (start_in) begin
      rise_cnt_r <= 5'h00;
    end else if (tick && !sclk_out) begin
      rise_cnt_r <= rise_cnt_r + 5'h01;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  chk_pulse_count: assert property (
    $fell(active_out) && !ext_mode_in |-> rise_cnt_r == 5'h0c)
    else $error("internal clock did not give twelve pulses");
  chk_sclk_idle_low: assert property (
    !active_out && !ext_mode_in |-> !sclk_out)
    else $error("internal clock not low between transfers");
  chk_ext_no_drive: assert property (
    ext_mode_in |=> sclk_oe_n_out)
    else $error("bit clock driven in external mode");
  cov_int_transfer: cover property ($fell(active_out) && !ext_mode_in);
  cov_ext_transfer: cover property ($fell(active_out) && ext_mode_in);
endmodule // adrp_ser

//--- adrp_port.sv
// Converter result byte port, serial clock select and APB status
`include "adrp_consts.svh"
`timescale 1ns/10ps
module adrp_port
  import adrp_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic cs_n_in,
  input wire logic read_conv_in,
  input wire logic byte_sel_in,
  input wire logic code_format_select_in,
  input wire logic serial_clock_source_select_in,
  input wire logic serial_bit_clock_in,
  input wire adrp_code_t raw_code_in,
  output logic [7:0] par_data_out,
  output logic [7:0] par_data_oe_n_out,
  output logic serial_bit_clock_out,
  output logic serial_bit_clock_oe_n_out,
  output logic serial_data_out,
  output logic busy_n_out,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out
);
  //////////////////////////////////////////////////////////////////////////
  logic rst_ff_r;
  logic rst_n;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_ff_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_ff_r <= 1'b1;
      rst_n <= rst_ff_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  logic [5:0] pins_s;
  logic cs_n_s;
  logic rc_s;
  logic byte_s;
  logic fmt_s;
  logic ext_s;
  logic xclk_s;

  adrp_sync #(.W(6)) u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .d_in({cs_n_in, read_conv_in, byte_sel_in, code_format_select_in,
           serial_clock_source_select_in, serial_bit_clock_in}),
    .q_out(pins_s)
  );

  assign {cs_n_s, rc_s, byte_s, fmt_s, ext_s, xclk_s} = pins_s;

  function automatic adrp_code_t fmt_code(adrp_code_t raw, logic sb);
    fmt_code = sb ? raw : {~raw[11], raw[10:0]};
  endfunction

  function automatic logic [7:0] byte_mux(adrp_code_t res, logic hi);
    byte_mux = hi ? {res[3:0], 4'h0} : res[11:4];
  endfunction

  //////////////////////////////////////////////////////////////////////////
  adrp_state_t state_r;
  logic [15:0] conv_cnt_r;
  logic [15:0] ctrl_r;
  logic strb_d_r;
  logic strb_s;
  logic start_w;
  logic cap_w;
  logic cap_d_r;
  adrp_code_t result_r;
  logic ser_active;

  // Chip select is ORed with read/convert; the later of the two falling edges converts
  assign strb_s = cs_n_s | rc_s;
  assign start_w = strb_d_r && !strb_s && (state_r == ST_IDLE);
  assign cap_w = (state_r == ST_CONV) && (conv_cnt_r == 16'h0000);

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      // Same level as the synchroniser reset, so no false edge follows
      strb_d_r <= 1'b0;
    end else begin
      strb_d_r <= strb_s;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      conv_cnt_r <= 16'h0000;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (start_w) begin
            state_r <= ST_CONV;
            // Zero in the register still gives a one-cycle conversion
            conv_cnt_r <= (ctrl_r == 16'h0000) ? 16'h0000 :
                          ctrl_r - 16'h0001;
          end
        end
        ST_CONV: begin
          if (cap_w) begin
            state_r <= ST_IDLE;
          end else begin
            conv_cnt_r <= conv_cnt_r - 16'h0001;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      result_r <= 12'h000;
    end else if (cap_w) begin
      result_r <= fmt_code(raw_code_in, fmt_s);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cap_d_r <= 1'b0;
      busy_n_out <= 1'b1;
    end else begin
      cap_d_r <= cap_w;
      if (start_w) begin
        busy_n_out <= 1'b0;
      end else if (cap_d_r) begin
        busy_n_out <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Drive only when selected
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      par_data_oe_n_out <= 8'hff;
      par_data_out <= 8'h00;
    end else begin
      par_data_oe_n_out <= (cs_n_s || !rc_s) ? 8'hff : 8'h00;
      par_data_out <= byte_mux(result_r, byte_s);
    end
  end

  // Start pulse precedes capture, so the shifter gets the previous result
  adrp_ser u_ser (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .start_in(start_w),
    .ext_mode_in(ext_s),
    .ext_clk_in(xclk_s),
    .data_in(result_r),
    .sclk_out(serial_bit_clock_out),
    .sclk_oe_n_out(serial_bit_clock_oe_n_out),
    .sdata_out(serial_data_out),
    .active_out(ser_active)
  );

  //////////////////////////////////////////////////////////////////////////
  logic [31:0] rd_mux;
  logic mapped;
  logic [7:0] addr;

  assign addr = paddr_in[7:0];
  assign pready_out = psel_in && penable_in;

  always_comb begin
    rd_mux = 32'h0000_0000;
    mapped = (paddr_in[11:8] == 4'h0);
    case (addr)
      `ADRP_REG_CTRL: rd_mux = {16'h0000, ctrl_r};
      `ADRP_REG_STATUS: begin
        rd_mux[`ADRP_ST_BUSY] = (state_r == ST_CONV);
        rd_mux[`ADRP_ST_BYTE] = byte_s;
        rd_mux[`ADRP_ST_FMT] = fmt_s;
        rd_mux[`ADRP_ST_EXT] = ext_s;
        rd_mux[`ADRP_ST_SER] = ser_active;
      end
      `ADRP_REG_RESULT: rd_mux = {20'h00000, result_r};
      default: mapped = 1'b0;
    endcase
  end

  // Answer is prepared in the setup cycle so access needs no wait
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      prdata_out <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else if (psel_in && !penable_in) begin
      prdata_out <= pwrite_in ? 32'h0000_0000 : rd_mux;
      pslverr_out <= !mapped;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `ADRP_CONV_DEF;
    end else if (psel_in && penable_in && pwrite_in &&
                 paddr_in[11:8] == 4'h0 && addr == `ADRP_REG_CTRL) begin
      ctrl_r <= pwdata_in[15:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n);

  chk_format_straight: assert property (
    cap_w && fmt_s |=> result_r == $past(raw_code_in))
    else $error("straight binary result wrong");
  chk_format_twos: assert property (
    cap_w && !fmt_s |=>
      result_r == {~$past(raw_code_in[11]), $past(raw_code_in[10:0])})
    else $error("two's complement result wrong");
  chk_pins_float: assert property (
    cs_n_s || !rc_s |=> par_data_oe_n_out == 8'hff)
    else $error("data pins driven while deselected");
  chk_pins_drive: assert property (
    !cs_n_s && rc_s |=> par_data_oe_n_out == 8'h00)
    else $error("data pins not driven while selected");
  chk_upper_byte: assert property (
    !byte_s |=> par_data_out == $past(result_r[11:4]))
    else $error("upper byte wrong");
  chk_lower_byte: assert property (
    byte_s |=> par_data_out[7:4] == $past(result_r[3:0]))
    else $error("lower nibble wrong");
  chk_lower_ground: assert property (
    byte_s |=> par_data_out[3:0] == 4'h0)
    else $error("lower pins not grounded");
  chk_start_busy: assert property (
    $fell(strb_s) && state_r == ST_IDLE |=> !busy_n_out && state_r == ST_CONV)
    else $error("falling convert edge ignored");
  chk_busy_release: assert property (
    $rose(busy_n_out) |-> $past(cap_w, 2))
    else $error("busy released before update");
  chk_result_stable: assert property (
    !cap_w |=> $stable(result_r))
    else $error("result changed outside completion");
  // Busy timing, conversion ordering, data pin enables and result bits
  chk_busy_conv: assert property (
    state_r == ST_CONV |-> !busy_n_out)
    else $error("busy high during conversion");
  chk_busy_after_cap: assert property (
    cap_w |=> !busy_n_out)
    else $error("busy released with capture");
  chk_busy_outputs: assert property (
    $rose(busy_n_out) && !$past(byte_s) |->
      par_data_out == result_r[11:4])
    else $error("busy released before pins updated");
  chk_start_load: assert property (
    start_w |=> serial_data_out == $past(result_r[11]))
    else $error("serial start lost previous result");
  chk_start_ignored: assert property (
    state_r == ST_CONV && !cap_w |=> state_r == ST_CONV)
    else $error("conversion cut short");
  chk_oe_uniform: assert property (
    par_data_oe_n_out == 8'hff || par_data_oe_n_out == 8'h00)
    else $error("data pins split between drive and float");
  chk_format_low: assert property (
    cap_w |=> result_r[10:0] == $past(raw_code_in[10:0]))
    else $error("result low bits wrong");
  chk_result_on_cap: assert property (
    $changed(result_r) |-> $past(cap_w))
    else $error("result changed without completion");
  cov_conversion: cover property (start_w ##[1:1000] $rose(busy_n_out));
  cov_byte_high: cover property (!cs_n_s && rc_s && byte_s);
  cov_bus_error: cover property (pready_out && pslverr_out);
endmodule // adrp_port

//--- adrp_host.sv
// Host controller model for the converter control pins
`timescale 1ns/10ps
module adrp_host (
  input wire logic clk_in,
  input wire logic busy_n_in,
  input wire logic sdata_in,
  output logic cs_n_out,
  output logic read_conv_out,
  output logic byte_sel_out,
  output logic ext_clk_out
);
  initial begin
    cs_n_out = 1'b1;
    read_conv_out = 1'b1;
    byte_sel_out = 1'b0;
    ext_clk_out = 1'b0;
  end
  //////////////////////////////////////////////////////////////////
  task automatic pins(input logic cs, input logic rc, input logic bs);
    @(posedge clk_in);
    cs_n_out <= cs;
    read_conv_out <= rc;
    byte_sel_out <= bs;
  endtask
  // Bounded waits, a stuck busy must not hang the host
  task automatic finish_conv(output bit ok);
    int n;
    for (n = 0; n < 20 && busy_n_in !== 1'b0; n++) @(negedge clk_in);
    ok = (busy_n_in === 1'b0);
    for (n = 0; n < 400 && busy_n_in !== 1'b1; n++) @(negedge clk_in);
    ok = ok && (busy_n_in === 1'b1);
  endtask
  task automatic convert(input logic bs, output bit ok);
    pins(1'b0, 1'b0, bs);
    finish_conv(ok);
    pins(1'b0, 1'b1, bs);
    repeat (5) @(posedge clk_in);
  endtask
  // Bit clock stands low outside a frame
  task automatic ext_bit(output logic b);
    @(posedge clk_in);
    ext_clk_out <= 1'b1;
    repeat (5) @(posedge clk_in);
    @(negedge clk_in);
    b = sdata_in;
    @(posedge clk_in);
    ext_clk_out <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask
endmodule // adrp_host

//--- adrp_port_test.sv
// Self-checking bench for the converter result byte port
`timescale 1ns/10ps
module adrp_port_test;
  import adrp_pkg::*;
  localparam int CONV_N = 20;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic cs_n, rc, bsel, eclk, sclk, sclk_oe_n, sdata, busy_n, sclk_q;
  logic fmt = 1'b1;
  logic src = 1'b0;
  adrp_code_t raw = 12'h000;
  adrp_code_t exp_v, ser_word, word;
  adrp_code_t prev = 12'h000;
  logic [7:0] par, oe_n;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, b;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  int ser_cnt = 0;
  int base;
  bit ok;
  adrp_code_t raw_tab [4] = '{12'ha5c, 12'h3c7, 12'hfff, 12'h801};
  logic fmt_tab [4] = '{1'b1, 1'b1, 1'b0, 1'b0};

  always #5 clk_in = ~clk_in;

  adrp_port i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .cs_n_in(cs_n), .read_conv_in(rc), .byte_sel_in(bsel),
    .code_format_select_in(fmt), .serial_clock_source_select_in(src),
    .serial_bit_clock_in(eclk), .raw_code_in(raw), .par_data_out(par),
    .par_data_oe_n_out(oe_n), .serial_bit_clock_out(sclk),
    .serial_bit_clock_oe_n_out(sclk_oe_n), .serial_data_out(sdata),
    .busy_n_out(busy_n), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr));

  adrp_host i_host (.clk_in(clk_in), .busy_n_in(busy_n), .sdata_in(sdata),
    .cs_n_out(cs_n), .read_conv_out(rc), .byte_sel_out(bsel),
    .ext_clk_out(eclk));

  //////////////////////////////////////////////////////////////////
  // Internal bit clock monitor, captures data on its rising edge
  always @(posedge clk_in) begin
    sclk_q <= sclk;
    if (sclk === 1'b1 && sclk_q === 1'b0) begin
      ser_cnt <= ser_cnt + 1;
      ser_word <= {ser_word[10:0], sdata};
    end
  end

  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    @(posedge clk_in);
    while (pready !== 1'b1) @(posedge clk_in);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (4) @(negedge clk_in);
    chk("busy_n", 32'h1, busy_n);
    chk("oe_n", 32'hff, oe_n);
    chk("sclk_oe_n", 32'h0, sclk_oe_n);
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl_reset", 32'h3e8, rd);
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped_err", 32'h1, er);
    apb(1'b1, 12'h000, CONV_N);
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl_write", CONV_N, rd);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in);
      fmt <= fmt_tab[i];
      raw <= raw_tab[i];
      repeat (4) @(posedge clk_in);
      exp_v = fmt_tab[i] ? raw_tab[i] : {~raw_tab[i][11], raw_tab[i][10:0]};
      base = ser_cnt;
      i_host.convert(1'b0, ok);
      chk("busy_pulse", 32'h1, ok);
      @(negedge clk_in);
      chk("oe_n_drive", 32'h0, oe_n);
      chk("upper_byte", exp_v[11:4], par);
      i_host.pins(1'b0, 1'b1, 1'b1);
      raw <= ~raw_tab[i];
      repeat (5) @(negedge clk_in);
      chk("lower_byte", {exp_v[3:0], 4'h0}, par);
      apb(1'b0, 12'h008, 32'h0);
      chk("result_reg", exp_v, rd);
      chk("result_err", 32'h0, er);
      repeat (150) @(negedge clk_in);
      chk("ser_pulses", 32'd12, ser_cnt - base);
      chk("ser_word", prev, ser_word);
      chk("sclk_idle", 32'h0, sclk);
      prev = exp_v;
    end
    $display("test formats done");
    @(posedge clk_in);
    fmt <= 1'b1;
    raw <= 12'h5a3;
    i_host.pins(1'b1, 1'b0, 1'b0);
    repeat (5) @(negedge clk_in);
    chk("float_cs", 32'hff, oe_n);
    i_host.pins(1'b0, 1'b0, 1'b0);
    i_host.finish_conv(ok);
    chk("cs_start", 32'h1, ok);
    chk("float_rc", 32'hff, oe_n);
    i_host.pins(1'b0, 1'b1, 1'b0);
    repeat (5) @(negedge clk_in);
    chk("upper_cs", 32'h5a, par);
    repeat (150) @(posedge clk_in);
    $display("test float done");
    src <= 1'b1;
    raw <= 12'h0f0;
    repeat (5) @(negedge clk_in);
    chk("ext_sclk_oe_n", 32'h1, sclk_oe_n);
    base = ser_cnt;
    i_host.convert(1'b0, ok);
    chk("ext_busy", 32'h1, ok);
    for (int k = 0; k < 12; k++) begin
      i_host.ext_bit(b);
      word[11 - k] = b;
    end
    chk("ext_word", 32'h5a3, word);
    chk("ext_no_pulse", 32'h0, ser_cnt - base);
    apb(1'b0, 12'h004, 32'h0);
    chk("status", 32'h0c, rd);
    $display("test external clock done");
    conclude();
  end
endmodule // adrp_port_test
